// ### rtl/vsr_pkg.sv
// constants and state type for the voltage scaling register and ramp block
package vsr_pkg;

	////////////////////////////////////////////////////////////////////////
	// register addresses, low two bits of the address byte
	localparam logic [1:0] ADDR_FLOOR = 2'h0;
	localparam logic [1:0] ADDR_ROOF = 2'h1;
	localparam logic [1:0] ADDR_MODE = 2'h2;
	localparam logic [1:0] ADDR_RAMP = 2'h3;
	localparam logic [5:0] ADDR_UPPER_ZERO = 6'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'hFF;

	////////////////////////////////////////////////////////////////////////
	// voltage register fields
	localparam int CODE_MSB = 5;
	localparam int TUNE_BIT = 6;
	localparam int ENABLE_BIT = 7;

	// ramp control register fields
	localparam int SLEW_MSB = 2;
	localparam int STRAT_BIT = 5;
	localparam int GO_BIT = 7;
	localparam logic [2:0] SLEW_SINGLE = 3'h7;
	localparam logic [2:0] SLEW_MULTI_TOP = 3'h6;

	// mode register: forced pwm association per target register
	localparam int MODE_PWM_FLOOR = 0;
	localparam int MODE_PWM_ROOF = 1;

	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] RAMP_RESET = 8'h07;
	localparam logic TUNE_RESET = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// timing and scaling
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int STEP_UV_FINE = 12500;
	localparam int STEP_UV_COARSE = 25000;
	localparam logic [15:0] TIMER_ZERO = 16'h0000;

	typedef struct packed {
		logic en_s1;
		logic en_s2;
		logic sel_s1;
		logic sel_s2;
		logic [5:0] floor_code;
		logic [5:0] roof_code;
		logic tune;
		logic enable;
		logic [7:0] mode;
		logic [7:0] ramp;
		logic [5:0] target;
		logic [15:0] timer;
		logic ramping;
		logic regulated;
		logic run;
		logic [7:0] rdata;
		logic [21:0] target_uv;
	} vsr_state_t;

endpackage : vsr_pkg

// ### rtl/vsr_ramp.sv
// voltage setting registers and output target slew logic
// Operation
// - slew code 111: upward moves jump straight to the new target
// - single-step, down to a forced pwm target: jump immediately
// - single-step, down to a pfm target: jump, rate left unregulated
// - codes 000..110 regulate the ramp both ways, any strategy or mode
// - multi-step moves one code per interval set by the slew code
// - low six bits of each voltage register are a step code 0..63
// - target is minimum voltage plus code times 12.5 or 25 mV
// - bit 6 picks inductor tuning: 0 for 2.2 uH, 1 for 1 uH
// - bit 6 is one shared flop seen by both voltage registers
// - bit 7 gates the enable pin; 0 forces shutdown, 1 is default
// - bit 7 is likewise shared by both voltage registers
// - go bit only acts in software strategy
// - go defaults 0; writing 1 starts the move toward roof code
// - software strategy: go clears itself once target is reached
// - low two address bits select one of four 8-bit registers
// - hardware strategy: select pin picks floor/roof, writes act at once
// - reads of undefined addresses return FFh
`timescale 1ns/1ps
`default_nettype none

module vsr_ramp #(
	parameter logic [5:0] FLOOR_RESET_CODE = 6'h00,
	parameter logic [5:0] ROOF_RESET_CODE = 6'h00,
	parameter logic ENABLE_RESET = 1'b1,
	parameter logic COARSE_STEP = 1'b0,
	parameter int MIN_UV = 600000,
	parameter int STEP_BASE_NS = 1000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// register port from the serial slave
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// pins
	input wire logic enable_pin_in,
	input wire logic voltage_select_pin_in,
	// converter side
	output logic [5:0] target_code_out,
	output logic [21:0] target_uv_out,
	output logic ramping_out,
	output logic rate_regulated_out,
	output logic converter_run_out,
	output logic inductor_tune_out
);

	////////////////////////////////////////////////////////////////////////
	// derived constants; least interval rounds up
	localparam int BASE_CYC_RAW =
		(STEP_BASE_NS * (vsr_pkg::CLK_FREQ_KHZ / 1000) + 999) / 1000;
	localparam int BASE_CYC = (BASE_CYC_RAW < 1) ? 1 : BASE_CYC_RAW;
	localparam int STEP_UV = COARSE_STEP ?
		vsr_pkg::STEP_UV_COARSE : vsr_pkg::STEP_UV_FINE;

	localparam vsr_pkg::vsr_state_t ST_RESET = '{
		en_s1: 1'b0,
		en_s2: 1'b0,
		sel_s1: 1'b0,
		sel_s2: 1'b0,
		floor_code: FLOOR_RESET_CODE,
		roof_code: ROOF_RESET_CODE,
		tune: vsr_pkg::TUNE_RESET,
		enable: ENABLE_RESET,
		mode: vsr_pkg::MODE_RESET,
		ramp: vsr_pkg::RAMP_RESET,
		target: FLOOR_RESET_CODE,
		timer: vsr_pkg::TIMER_ZERO,
		ramping: 1'b0,
		regulated: 1'b1,
		run: 1'b0,
		rdata: vsr_pkg::READ_UNMAPPED,
		target_uv: 22'(MIN_UV + int'(FLOOR_RESET_CODE) * STEP_UV)
	};

	////////////////////////////////////////////////////////////////////////
	// functions

	// address byte maps to a register only when its upper bits are zero
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [1:0] idx);
		addr_hit = (a[7:2] == vsr_pkg::ADDR_UPPER_ZERO) && (a[1:0] == idx);
	endfunction : addr_hit

	// cycles between micro-steps; slower codes double the gap
	function automatic logic [15:0] step_gap(input logic [2:0] slew);
		logic [2:0] sh;
		sh = vsr_pkg::SLEW_MULTI_TOP - slew;
		step_gap = 16'(BASE_CYC) << sh;
	endfunction : step_gap

	////////////////////////////////////////////////////////////////////////
	// state

	vsr_pkg::vsr_state_t st_r;
	vsr_pkg::vsr_state_t st_nxt;

	logic [5:0] sel_code;
	logic sel_pwm;
	logic hw_strat;
	logic single;
	logic active;
	logic moving;
	logic go_write;

	always_comb
	begin
		st_nxt = st_r;

		// pin synchronisers
		st_nxt.en_s1 = enable_pin_in;
		st_nxt.en_s2 = st_r.en_s1;
		st_nxt.sel_s1 = voltage_select_pin_in;
		st_nxt.sel_s2 = st_r.sel_s1;

		// register writes
		go_write = 1'b0;
		if (reg_wr_in)
		begin
			if (addr_hit(reg_addr_in, vsr_pkg::ADDR_FLOOR))
			begin
				st_nxt.floor_code = reg_wdata_in[vsr_pkg::CODE_MSB:0];
				st_nxt.tune = reg_wdata_in[vsr_pkg::TUNE_BIT];
				st_nxt.enable = reg_wdata_in[vsr_pkg::ENABLE_BIT];
			end
			if (addr_hit(reg_addr_in, vsr_pkg::ADDR_ROOF))
			begin
				st_nxt.roof_code = reg_wdata_in[vsr_pkg::CODE_MSB:0];
				st_nxt.tune = reg_wdata_in[vsr_pkg::TUNE_BIT];
				st_nxt.enable = reg_wdata_in[vsr_pkg::ENABLE_BIT];
			end
			if (addr_hit(reg_addr_in, vsr_pkg::ADDR_MODE))
			begin
				st_nxt.mode = reg_wdata_in;
			end
			if (addr_hit(reg_addr_in, vsr_pkg::ADDR_RAMP))
			begin
				st_nxt.ramp = reg_wdata_in;
				go_write = reg_wdata_in[vsr_pkg::GO_BIT];
			end
		end

		// selected code; software strategy always heads for the roof
		hw_strat = st_r.ramp[vsr_pkg::STRAT_BIT];
		single = st_r.ramp[vsr_pkg::SLEW_MSB:0] == vsr_pkg::SLEW_SINGLE;
		if (hw_strat && !st_r.sel_s2)
		begin
			sel_code = st_r.floor_code;
			sel_pwm = st_r.mode[vsr_pkg::MODE_PWM_FLOOR];
		end
		else
		begin
			sel_code = st_r.roof_code;
			sel_pwm = st_r.mode[vsr_pkg::MODE_PWM_ROOF];
		end

		// go is ignored under the hardware strategy
		active = hw_strat || st_r.ramp[vsr_pkg::GO_BIT];
		moving = active && (st_r.target != sel_code);

		if (moving && single)
		begin
			// one jump; a pfm target drops at the load's pace, unregulated
			st_nxt.target = sel_code;
			st_nxt.regulated = (sel_code > st_r.target) || sel_pwm;
			st_nxt.timer = step_gap(vsr_pkg::SLEW_MULTI_TOP);
		end
		else if (moving)
		begin
			st_nxt.regulated = 1'b1;
			if (st_r.timer == vsr_pkg::TIMER_ZERO)
			begin
				// steps track sel_code live, so a new code redirects
				if (sel_code > st_r.target)
				begin
					st_nxt.target = st_r.target + 6'h01;
				end
				else
				begin
					st_nxt.target = st_r.target - 6'h01;
				end
				st_nxt.timer = step_gap(st_r.ramp[vsr_pkg::SLEW_MSB:0]) -
					16'h0001;
			end
			else
			begin
				st_nxt.timer = st_r.timer - 16'h0001;
			end
		end
		else
		begin
			// first micro-step waits a full interval after the request
			st_nxt.timer = step_gap(st_nxt.ramp[vsr_pkg::SLEW_MSB:0]) -
				16'h0001;
			if (st_nxt.ramp[vsr_pkg::SLEW_MSB:0] ==
				vsr_pkg::SLEW_SINGLE)
			begin
				st_nxt.timer = vsr_pkg::TIMER_ZERO;
			end
		end
		st_nxt.ramping = active && (st_nxt.target != sel_code);

		// self clear on arrival; a fresh write of one wins over it
		if (!hw_strat && st_r.ramp[vsr_pkg::GO_BIT] &&
			(st_r.target == st_r.roof_code) && !go_write)
		begin
			st_nxt.ramp[vsr_pkg::GO_BIT] = 1'b0;
		end

		// shutdown bit overrides the pin
		st_nxt.run = st_nxt.enable && st_r.en_s2;

		st_nxt.target_uv = 22'(MIN_UV) +
			22'(st_nxt.target) * 22'(STEP_UV);

		// read data, registered one cycle after the strobe
		if (reg_rd_in)
		begin
			if (addr_hit(reg_addr_in, vsr_pkg::ADDR_FLOOR))
			begin
				st_nxt.rdata = {st_r.enable, st_r.tune, st_r.floor_code};
			end
			else if (addr_hit(reg_addr_in, vsr_pkg::ADDR_ROOF))
			begin
				st_nxt.rdata = {st_r.enable, st_r.tune, st_r.roof_code};
			end
			else if (addr_hit(reg_addr_in, vsr_pkg::ADDR_MODE))
			begin
				st_nxt.rdata = st_r.mode;
			end
			else if (addr_hit(reg_addr_in, vsr_pkg::ADDR_RAMP))
			begin
				st_nxt.rdata = st_r.ramp;
			end
			else
			begin
				st_nxt.rdata = vsr_pkg::READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			st_r <= ST_RESET;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata_out = st_r.rdata;
	assign target_code_out = st_r.target;
	assign target_uv_out = st_r.target_uv;
	assign ramping_out = st_r.ramping;
	assign rate_regulated_out = st_r.regulated;
	assign converter_run_out = st_r.run;
	assign inductor_tune_out = st_r.tune;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	a_single_up_jump: assert property (
		moving && single && (sel_code > st_r.target)
		|=> st_r.target == $past(sel_code) && st_r.regulated)
		else $error("single step up did not jump");

	a_pwm_down_jump: assert property (
		moving && single && (sel_code < st_r.target) && sel_pwm
		|=> st_r.target == $past(sel_code) && st_r.regulated)
		else $error("pwm target not applied at once");

	a_pfm_down_free: assert property (
		moving && single && (sel_code < st_r.target) && !sel_pwm
		|=> !st_r.regulated)
		else $error("pfm drop marked regulated");

	a_multi_one_code: assert property (
		!single && moving && st_r.timer != vsr_pkg::TIMER_ZERO
		|=> $stable(st_r.target))
		else $error("micro-step before interval ran out");

	a_multi_step_size: assert property (
		!single && moving && st_r.timer == vsr_pkg::TIMER_ZERO
		|=> (st_r.target == $past(st_r.target) + 6'h01) ||
			(st_r.target == $past(st_r.target) - 6'h01))
		else $error("micro-step not one code");

	a_shared_tune_bit: assert property (
		reg_wr_in && (addr_hit(reg_addr_in, vsr_pkg::ADDR_FLOOR) ||
			addr_hit(reg_addr_in, vsr_pkg::ADDR_ROOF))
		|=> st_r.tune == $past(reg_wdata_in[vsr_pkg::TUNE_BIT]) &&
			st_r.enable == $past(reg_wdata_in[vsr_pkg::ENABLE_BIT]))
		else $error("shared bits not updated");

	a_enable_gates_run: assert property (
		!st_r.enable |-> !converter_run_out)
		else $error("converter runs while disabled");

	a_go_idle_hold: assert property (
		!hw_strat && !st_r.ramp[vsr_pkg::GO_BIT] |=> $stable(st_r.target))
		else $error("target moved without go");

	a_go_self_clear: assert property (
		!hw_strat && st_r.ramp[vsr_pkg::GO_BIT] &&
		st_r.target == st_r.roof_code && !reg_wr_in
		|=> !st_r.ramp[vsr_pkg::GO_BIT])
		else $error("go bit not cleared on arrival");

	a_unmapped_reads_ff: assert property (
		reg_rd_in && reg_addr_in[7:2] != vsr_pkg::ADDR_UPPER_ZERO
		|=> reg_rdata_out == vsr_pkg::READ_UNMAPPED)
		else $error("unmapped read not FFh");

endmodule : vsr_ramp

`default_nettype wire

// ### verif/tb_voltage_scaling_regs_ramp.sv
// self-checking bench for the voltage register and ramp block
`timescale 1ns/1ps
`default_nettype none
module tb_voltage_scaling_regs_ramp;
	// short base interval keeps slew 0 affordable
	localparam int BASE = 2;
	localparam int MIN_UV = 600000;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic en_pin = 1'b1;
	logic sel_pin = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, ramping, regd, run, tune;
	logic [5:0] tcode, c;
	logic [21:0] tuv;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h8208;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #4 clk_in = ~clk_in;
	vsr_master master (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	vsr_ramp #(.FLOOR_RESET_CODE(6'h05), .ROOF_RESET_CODE(6'h0A),
		.MIN_UV(MIN_UV), .STEP_BASE_NS(16)) DUT (.clk_in(clk_in),
		.nrst_in(nrst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.enable_pin_in(en_pin), .voltage_select_pin_in(sel_pin),
		.target_code_out(tcode), .target_uv_out(tuv), .ramping_out(ramping),
		.rate_regulated_out(regd), .converter_run_out(run),
		.inductor_tune_out(tune));
	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [5:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[5:0];
	endfunction : rnd
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		master.access(a, d, 1'b1);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		master.access(a, 8'h00, 1'b0);
	endtask : rd_reg
	// lim bounds the wait: a few edges for a written jump, more when the select pin must pass the synchroniser
	task automatic wait_code(input logic [5:0] v, input int lim);
		int n;
		n = 0;
		while (tcode !== v && n < lim)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk(tcode, v);
		chk(tuv, MIN_UV + v * 12500);
	endtask : wait_code
	// first change may follow a redirect, so only the second gap is timed
	task automatic step_gap(input int s);
		logic [5:0] p;
		int n;
		for (int k = 0; k < 2; k++)
		begin
			p = tcode;
			n = 0;
			while (tcode === p && n < 300)
			begin
				@(posedge clk_in);
				#1;
				n++;
			end
			// odd slews head for the floor and land on it at the second step
			chk(ramping, k == 0 || s % 2 == 0);
		end
		chk(n, BASE << (6 - s));
		chk(tcode === p + 6'h01 || tcode === p - 6'h01, 1);
	endtask : step_gap
	////////////////////////////////////////////////////////////////////////
	// read data is judged the edge after its strobe
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done();
		end
		if (rd === 1'b1)
		begin
			#2;
			chk(rdata, exp_q.pop_front());
		end
	end
	initial
	begin
		repeat (20) @(posedge clk_in);
		#1;
		nrst_in = 1'b1;
		rd_reg(8'h00, 8'hC5);
		rd_reg(8'h01, 8'hCA);
		rd_reg(8'h02, 8'h00);
		rd_reg(8'h03, 8'h07);
		rd_reg(8'h04, 8'hFF);
		wr_reg(8'h41, 8'h00);
		rd_reg(8'h01, 8'hCA);
		wr_reg(8'h00, 8'h05);
		rd_reg(8'h01, 8'h0A);
		chk(tune, 0);
		chk(run, 0);
		wr_reg(8'h01, 8'hCA);
		rd_reg(8'h00, 8'hC5);
		chk(run, 1);
		en_pin = 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		chk(run, 0);
		en_pin = 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		chk(run, 1);
		c = rnd() | 6'h20;
		wr_reg(8'h01, {2'h3, c});
		chk(tcode, 6'h05);
		wr_reg(8'h03, 8'h87);
		wait_code(c, 2);
		rd_reg(8'h03, 8'h07);
		wr_reg(8'h02, 8'h02);
		wr_reg(8'h01, 8'hC3);
		wr_reg(8'h03, 8'h87);
		wait_code(6'h03, 2);
		chk(regd, 1);
		wr_reg(8'h01, {2'h3, c});
		wr_reg(8'h03, 8'hA7);
		wait_code(6'h05, 6);
		sel_pin = 1'b1;
		wait_code(c, 6);
		c = rnd() | 6'h20;
		wr_reg(8'h01, {2'h3, c});
		wait_code(c, 3);
		wr_reg(8'h00, 8'hC7);
		repeat (3) @(posedge clk_in);
		#1;
		wait_code(c, 3);
		wr_reg(8'h02, 8'h01);
		sel_pin = 1'b0;
		wait_code(6'h07, 6);
		chk(regd, 1);
		sel_pin = 1'b1;
		wait_code(c, 6);
		wr_reg(8'h02, 8'h00);
		sel_pin = 1'b0;
		wait_code(6'h07, 6);
		chk(regd, 0);
		wr_reg(8'h00, 8'hC0);
		wr_reg(8'h01, 8'hFF);
		for (int s = 0; s < 7; s++)
		begin
			wr_reg(8'h03, 8'h20 | s[7:0]);
			sel_pin = ~sel_pin;
			step_gap(s);
		end
		test_done();
	end
endmodule : tb_voltage_scaling_regs_ramp
`default_nettype wire

// ### verif/vsr_master.sv
// register port master standing in for the application processor
`timescale 1ns/1ps
`default_nettype none
module vsr_master (
	// clock
	input wire logic clk_in,
	// register port
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// one strobe per byte; released lines show the inverse, not the old value
	task automatic access(input logic [7:0] a, input logic [7:0] d,
		input logic w);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask : access
endmodule : vsr_master
`default_nettype wire
